// [inc/cfp_pkg.sv]
package cfp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned FRAME_PERIOD_MS = 10;
  localparam int unsigned LATE_LIMIT_MS = 20;
  localparam int unsigned STROBE_NS = 330;
  localparam int unsigned FRAME_CYCLES = FRAME_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned LATE_CYCLES = LATE_LIMIT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Frame layout and sizes
  // ----------------------------------------
  localparam int unsigned FRAME_BYTES = 10;
  localparam int unsigned FRAME_SAMPLES = 80;
  localparam int unsigned SAMPLE_CYCLES = FRAME_CYCLES / FRAME_SAMPLES;
  localparam int unsigned HDR_EVERY = 50;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned DL_DEPTH = 1024;
  localparam int unsigned DL_ADDR_W = 10;
  localparam int unsigned DL_WORD_W = 20;
  localparam int unsigned FIFO_DEPTH = 16;
  // Header fill byte, arbitrary value
  localparam logic [BYTE_W-1:0] HDR_BYTE = 8'hA5;
  // Level of the data lines when nobody drives them
  localparam logic [BYTE_W-1:0] BUS_IDLE = 8'hFF;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [1:0] {CFP_IDLE, CFP_DECODE, CFP_ENCODE, CFP_PROGRAM} cfp_mode_t;
endpackage

// [inc/cfp_port_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cfp_port_if;
  import cfp_pkg::*;
  logic host_request_line;
  logic read_strobe_n;
  logic byte_avail_n;
  logic frame_request;
  logic [BYTE_W-1:0] dev_dout;
  logic dev_oe_n;
  logic [BYTE_W-1:0] host_dout;
  logic host_oe_n;
  // Resolved data lines; bit 7 is data_msb_line
  logic [BYTE_W-1:0] parallel_port;
  assign parallel_port = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : BUS_IDLE);
  modport device(
    input host_request_line, read_strobe_n, parallel_port,
    output byte_avail_n, frame_request, dev_dout, dev_oe_n
  );
  modport host(
    output host_request_line, read_strobe_n, host_dout, host_oe_n,
    input byte_avail_n, frame_request, parallel_port
  );
endinterface
`default_nettype wire

// [design/cfp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module cfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import cfp_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } cfp_fifo_st_t;
  cfp_fifo_st_t s, next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty; depth must be a power of two
  assign in_ready = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
  assign out_valid = s.wr != s.rd;
  assign out_data = mem[s.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [design/cfp_device.sv]
// Operation
// - Decode starts on command, requests frame every 10ms
// - Late host answer tolerated until buffer empty
// - Late encoded read tolerated until buffer overflows
// - Host loads encoder routine before encoder start
// - Frame is 80 one-bit samples in 10 bytes
// - 80 input samples make one frame; optional echo
// - Decoded samples scaled by volume and mute
// - 1k-word download; running it blocks voice modes
// - Download by write, execution by separate run
// - Host sends decode bytes pair-swapped
// - Encoder sends bytes pair-swapped
// - Eight data lines, MSB on top line
// - Encoded output one 10-byte frame per 10ms
// - Header burst before each 50 frames when enabled
// - Host holds request line high while reading
// - Byte-available low while a byte is buffered
// - Host reads each byte with one strobe pulse
// - Drive data at strobe fall, release at rise
`timescale 1ns/1ps
`default_nettype none
module cfp_device #(
  parameter int unsigned FRAME_CYC = cfp_pkg::FRAME_CYCLES,
  parameter int unsigned LATE_CYC = cfp_pkg::LATE_CYCLES,
  parameter int unsigned SAMPLE_CYC = cfp_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Parallel link
  cfp_port_if.device port,
  // Commands and settings
  input wire logic start_decode,
  input wire logic start_encode,
  input wire logic stop,
  input wire logic header_en,
  input wire logic monitor_en,
  input wire logic mute,
  input wire logic [cfp_pkg::SAMPLE_W-1:0] volume,
  // Program download
  input wire logic dl_we,
  input wire logic [cfp_pkg::DL_ADDR_W-1:0] dl_addr,
  input wire logic [cfp_pkg::DL_WORD_W-1:0] dl_data,
  input wire logic dl_run,
  output logic [cfp_pkg::DL_WORD_W-1:0] dl_rdata,
  // Audio in
  input wire logic [cfp_pkg::SAMPLE_W-1:0] in_sample,
  input wire logic in_valid,
  output logic in_ready,
  // Audio out
  output logic [cfp_pkg::SAMPLE_W-1:0] out_sample,
  output logic out_valid,
  // Status
  output cfp_pkg::cfp_mode_t mode,
  output logic code_loaded,
  output logic underrun,
  output logic late,
  output logic overflow
);
  import cfp_pkg::*;
  typedef struct packed {
    cfp_mode_t mode;
    logic loaded;
    logic [19:0] tick;
    logic [20:0] late_cnt;
    logic [13:0] sp_cnt;
    logic req;
    logic req_d;
    logic buf_full;
    logic underrun;
    logic late;
    logic overflow;
    logic [3:0] rx_idx;
    logic [0:FRAME_BYTES-1][BYTE_W-1:0] rx_buf;
    logic [FRAME_SAMPLES-1:0] play;
    logic [6:0] play_left;
    logic [2:0] bit_cnt;
    logic [6:0] pack;
    logic [3:0] byte_idx;
    logic [5:0] frame_cnt;
    logic [BYTE_W-1:0] hold;
    logic [BYTE_W-1:0] q0;
    logic [BYTE_W-1:0] q1;
    logic [1:0] qn;
    logic [3:0] hdr_left;
    logic strobe_d;
    logic drive;
    logic [BYTE_W-1:0] dout;
    logic [SAMPLE_W-1:0] out_sample;
    logic out_valid;
    logic [DL_WORD_W-1:0] dl_rdata;
  } cfp_dev_st_t;
  cfp_dev_st_t s, next_s;
  logic [DL_WORD_W-1:0] prog_ram [DL_DEPTH];
  logic push;
  logic [BYTE_W-1:0] push_data;
  logic fifo_in_ready;
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic pop;
  logic accept;
  logic smp_bit;
  logic [BYTE_W-1:0] new_byte;
  logic [3:0] rx_slot;
  logic dl_ok;

  // ----------------------------------------
  // Output buffer between encoder and link
  // ----------------------------------------
  cfp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(push_data),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // ----------------------------------------
  // Link and user outputs
  // ----------------------------------------
  assign port.byte_avail_n = !fifo_valid;
  assign port.frame_request = s.req;
  assign port.dev_dout = s.dout;
  assign port.dev_oe_n = !s.drive;
  assign in_ready = (s.mode == CFP_ENCODE) && (s.qn == 2'h0) && (s.hdr_left == 4'h0);
  assign accept = in_valid && in_ready;
  assign smp_bit = !in_sample[SAMPLE_W-1];
  assign new_byte = {s.pack, smp_bit};
  // Host sent the pair swapped; put each byte back in its standard slot
  assign rx_slot = {s.rx_idx[3:1], !s.rx_idx[0]};
  assign dl_ok = dl_we && (s.mode != CFP_PROGRAM);
  assign out_sample = s.out_sample;
  assign out_valid = s.out_valid;
  assign dl_rdata = s.dl_rdata;
  assign mode = s.mode;
  assign code_loaded = s.loaded;
  assign underrun = s.underrun;
  assign late = s.late;
  assign overflow = s.overflow;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.out_valid = 1'b0;
    next_s.req_d = port.host_request_line;
    next_s.strobe_d = port.read_strobe_n;
    next_s.dl_rdata = prog_ram[dl_addr];
    push = 1'b0;
    push_data = s.q0;
    pop = 1'b0;
    if (dl_ok) begin
      next_s.loaded = 1'b1;
    end
    // Mode control; a running download locks out voice work
    unique case (s.mode)
      CFP_IDLE: begin
        if (dl_run && s.loaded) begin
          next_s.mode = CFP_PROGRAM;
        end else if (start_decode) begin
          next_s.mode = CFP_DECODE;
          next_s.req = 1'b1;
          next_s.tick = '0;
          next_s.late_cnt = '0;
          next_s.rx_idx = '0;
          next_s.buf_full = 1'b0;
          next_s.play_left = '0;
          next_s.underrun = 1'b0;
          next_s.late = 1'b0;
        end else if (start_encode && s.loaded) begin
          next_s.mode = CFP_ENCODE;
          next_s.bit_cnt = '0;
          next_s.byte_idx = '0;
          next_s.frame_cnt = '0;
          next_s.qn = '0;
          next_s.overflow = 1'b0;
          next_s.hdr_left = header_en ? 4'(FRAME_BYTES) : 4'h0;
        end
      end
      CFP_DECODE, CFP_ENCODE, CFP_PROGRAM: begin
        if (stop) begin
          next_s.mode = CFP_IDLE;
          next_s.req = 1'b0;
        end
      end
    endcase
    // Decode: take bytes on the rising request edge
    if (s.mode == CFP_DECODE) begin
      if (s.req && port.host_request_line && !s.req_d) begin
        next_s.rx_buf[rx_slot] = port.parallel_port;
        next_s.rx_idx = s.rx_idx + 4'h1;
        if (s.rx_idx == 4'(FRAME_BYTES - 1)) begin
          next_s.buf_full = 1'b1;
          next_s.req = 1'b0;
        end
      end
      // A slow host only raises a flag; nothing is lost while data remains
      if (s.req && !s.late) begin
        next_s.late_cnt = s.late_cnt + 21'h1;
        if (s.late_cnt == 21'(LATE_CYC - 1)) begin
          next_s.late = 1'b1;
        end
      end
      next_s.tick = s.tick + 20'h1;
      if (s.tick == 20'(FRAME_CYC - 1)) begin
        next_s.tick = '0;
        if (s.buf_full) begin
          next_s.play = s.rx_buf;
          next_s.play_left = 7'(FRAME_SAMPLES);
          next_s.buf_full = 1'b0;
          next_s.req = 1'b1;
          next_s.rx_idx = '0;
          next_s.late_cnt = '0;
        end else begin
          next_s.underrun = 1'b1;
        end
      end
    end
    // Playback: one bit per sample, scaled by volume or muted
    if (s.play_left != 7'h0) begin
      next_s.sp_cnt = s.sp_cnt + 14'h1;
      if (s.sp_cnt == 14'(SAMPLE_CYC - 1)) begin
        next_s.sp_cnt = '0;
        next_s.out_valid = 1'b1;
        next_s.out_sample = mute ? '0 : (s.play[FRAME_SAMPLES-1] ? volume : (~volume + 16'h0001));
        next_s.play = {s.play[FRAME_SAMPLES-2:0], 1'b0};
        next_s.play_left = s.play_left - 7'h1;
      end
    end
    // Encode: pack sample signs, eight to a byte, ten bytes a frame
    if (s.mode == CFP_ENCODE) begin
      if (in_valid && !in_ready) begin
        next_s.overflow = 1'b1;
      end
      if (accept) begin
        next_s.out_valid = monitor_en;
        next_s.out_sample = in_sample;
        next_s.pack = new_byte[6:0];
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == 3'h7) begin
          if (!s.byte_idx[0]) begin
            next_s.hold = new_byte;
          end else begin
            next_s.q0 = new_byte;
            next_s.q1 = s.hold;
            next_s.qn = 2'h2;
          end
          next_s.byte_idx = s.byte_idx + 4'h1;
          if (s.byte_idx == 4'(FRAME_BYTES - 1)) begin
            next_s.byte_idx = '0;
            next_s.frame_cnt = s.frame_cnt + 6'h1;
            if (s.frame_cnt == 6'(HDR_EVERY - 1)) begin
              next_s.frame_cnt = '0;
              next_s.hdr_left = header_en ? 4'(FRAME_BYTES) : 4'h0;
            end
          end
        end
      end
      // Swapped pair goes first, then any pending header burst
      if (s.qn != 2'h0) begin
        push = 1'b1;
        if (fifo_in_ready) begin
          next_s.q0 = s.q1;
          next_s.qn = s.qn - 2'h1;
        end
      end else if (s.hdr_left != 4'h0) begin
        push = 1'b1;
        push_data = HDR_BYTE;
        if (fifo_in_ready) begin
          next_s.hdr_left = s.hdr_left - 4'h1;
        end
      end
      // Read strobe: drive on fall, release and pop on rise
      if (s.strobe_d && !port.read_strobe_n && port.host_request_line && fifo_valid) begin
        next_s.dout = fifo_data;
        next_s.drive = 1'b1;
      end
      if (s.drive && !s.strobe_d && port.read_strobe_n) begin
        next_s.drive = 1'b0;
        pop = 1'b1;
      end
    end else begin
      next_s.drive = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.strobe_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Downloaded code store, unwritable while it runs
  always_ff @(posedge clk) begin
    if (dl_ok) begin
      prog_ram[dl_addr] <= dl_data;
    end
  end
endmodule
`default_nettype wire

// [design/cfp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cfp_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Parallel link
  cfp_port_if.host port,
  // Encoded read side
  input wire logic read_en,
  output logic [cfp_pkg::BYTE_W-1:0] rx_byte,
  output logic rx_valid,
  // Decode write side, standard byte order
  input wire logic [cfp_pkg::BYTE_W-1:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready
);
  import cfp_pkg::*;
  typedef enum {H_IDLE, H_SETUP, H_PULSE, H_HOLD, H_RLOW, H_RGAP} cfp_hst_t;
  typedef struct packed {
    cfp_hst_t st;
    logic [7:0] cnt;
    logic [BYTE_W-1:0] b0;
    logic [BYTE_W-1:0] b1;
    logic have0;
    logic pair;
    logic half;
    logic req;
    logic strobe_n;
    logic oe_n;
    logic [BYTE_W-1:0] dout;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_valid;
  } cfp_host_st_t;
  cfp_host_st_t s, next_s;
  logic cnt_done;

  assign port.host_request_line = s.req | read_en;
  assign port.read_strobe_n = s.strobe_n;
  assign port.host_oe_n = s.oe_n;
  assign port.host_dout = s.dout;
  assign rx_byte = s.rx_byte;
  assign rx_valid = s.rx_valid;
  assign tx_ready = !s.pair;
  assign cnt_done = s.cnt == 8'(STROBE_CYCLES - 1);

  // Sequencer for strobe reads and request-edge writes
  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    next_s.cnt = s.cnt + 8'h1;
    if (tx_valid && !s.pair) begin
      if (!s.have0) begin
        next_s.b0 = tx_byte;
        next_s.have0 = 1'b1;
      end else begin
        next_s.b1 = tx_byte;
        next_s.have0 = 1'b0;
        next_s.pair = 1'b1;
      end
    end
    unique case (s.st)
      H_IDLE: begin
        next_s.cnt = '0;
        if (read_en && !port.byte_avail_n) begin
          next_s.st = H_RLOW;
          next_s.strobe_n = 1'b0;
        end else if (!read_en && port.frame_request && s.pair) begin
          next_s.st = H_SETUP;
          next_s.dout = s.half ? s.b0 : s.b1; // Second byte of a pair leaves first
          next_s.oe_n = 1'b0;
        end
      end
      H_SETUP: begin
        if (cnt_done) begin
          next_s.st = H_PULSE;
          next_s.cnt = '0;
          next_s.req = 1'b1;
        end
      end
      H_PULSE: begin
        if (cnt_done) begin
          next_s.st = H_HOLD;
          next_s.cnt = '0;
          next_s.req = 1'b0;
        end
      end
      H_HOLD: begin
        if (cnt_done) begin
          next_s.st = H_IDLE;
          next_s.oe_n = 1'b1;
          next_s.half = !s.half;
          next_s.pair = !s.half;
        end
      end
      H_RLOW: begin
        if (cnt_done) begin
          next_s.st = H_RGAP;
          next_s.cnt = '0;
          next_s.rx_byte = port.parallel_port;
          next_s.rx_valid = 1'b1;
          next_s.strobe_n = 1'b1;
        end
      end
      H_RGAP: begin
        if (cnt_done) begin
          next_s.st = H_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= H_IDLE;
      s.strobe_n <= 1'b1;
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// [tb/cfp_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cfp_checker #(
  parameter int unsigned FRAME_CYC = 2000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link lines
  input wire logic host_request_line,
  input wire logic read_strobe_n,
  input wire logic byte_avail_n,
  input wire logic frame_request,
  input wire logic [cfp_pkg::BYTE_W-1:0] dev_dout,
  input wire logic dev_oe_n,
  input wire logic [cfp_pkg::BYTE_W-1:0] parallel_port
);
  import cfp_pkg::*;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [3:0] wr_cnt;
  logic [31:0] gap;
  logic [1:0] rises;
  logic hrl_q;
  logic frq_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bytes written per request, and spacing of requests; the first gap is skipped
  // because it is measured from the start command, not from the frame timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= 4'h0;
      gap <= 32'h0;
      rises <= 2'h0;
      hrl_q <= 1'b0;
      frq_q <= 1'b0;
    end else begin
      hrl_q <= host_request_line;
      frq_q <= frame_request;
      if (!frame_request) begin
        wr_cnt <= 4'h0;
      end else if (host_request_line && !hrl_q) begin
        wr_cnt <= wr_cnt + 4'h1;
      end
      if (frame_request && !frq_q) begin
        gap <= 32'h1;
        if (rises != 2'h3) begin
          rises <= rises + 2'h1;
        end
      end else if (gap != 32'h0) begin
        gap <= gap + 32'h1;
      end
    end
  end
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_read_start;
    $fell(read_strobe_n) && host_request_line && !byte_avail_n;
  endsequence
  sequence s_quiet;
    read_strobe_n [*5];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_drive_on_fall: assert property (s_read_start |-> ##[1:3] !dev_oe_n)
    else $error("data not driven after strobe fall");
  chk_release_on_rise: assert property ($rose(read_strobe_n) |-> ##[1:3] dev_oe_n)
    else $error("data not released after strobe rise");
  chk_data_steady: assert property (!dev_oe_n && !$past(dev_oe_n) |-> $stable(dev_dout))
    else $error("driven byte changed during read");
  chk_drive_cause: assert property ($fell(dev_oe_n) |-> !read_strobe_n && $past(byte_avail_n) == 1'b0)
    else $error("drive without strobe or available byte");
  chk_avail_holds: assert property (s_quiet ##0 !byte_avail_n |=> !byte_avail_n)
    else $error("byte available dropped without a read");
  chk_released_idle: assert property (s_quiet |-> dev_oe_n)
    else $error("data lines driven with strobe idle");
  chk_port_msb: assert property (!dev_oe_n |-> parallel_port[BYTE_W-1] == dev_dout[BYTE_W-1])
    else $error("top data line does not carry msb");
  chk_burst_len: assert property ($rose(host_request_line) && frame_request && wr_cnt == 4'h9
    |-> ##[1:2] !frame_request)
    else $error("request kept after ten bytes");
  chk_burst_max: assert property (wr_cnt <= 4'hA)
    else $error("more than ten bytes in one frame");
  chk_frame_period: assert property ($rose(frame_request) && rises >= 2'h2 |-> gap == FRAME_CYC)
    else $error("frame request spacing wrong");
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  import cfp_pkg::*;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  localparam int unsigned FRAME_T = 2000;
  int failures = 0;
  int checks = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_decode = 1'b0, start_encode = 1'b0, stop = 1'b0, dl_run = 1'b0, dl_we = 1'b0;
  logic header_en = 1'b0, monitor_en = 1'b0, mute = 1'b0, read_en = 1'b0, in_valid = 1'b0;
  logic tx_valid = 1'b0;
  logic [15:0] volume = 16'h1234, in_sample = 16'h0000, out_sample;
  logic [9:0] dl_addr = 10'h000;
  logic [19:0] dl_data = 20'h00000, dl_rdata;
  logic [7:0] tx_byte = 8'h00, rx_byte;
  logic in_ready, out_valid, code_loaded, underrun, late, overflow, rx_valid, tx_ready;
  cfp_mode_t mode;
  logic [15:0] ins[$], outq[$];
  logic [7:0] rxq[$], frm[20];
  logic [9:0] ta[4] = '{10'h000, 10'h3FF, 10'h005, 10'h155};
  logic [19:0] tdv[4];
  // ----------------------------------------
  // Design ends and checker
  // ----------------------------------------
  cfp_port_if port_if();
  cfp_device #(.FRAME_CYC(FRAME_T), .LATE_CYC(2 * FRAME_T), .SAMPLE_CYC(5)) cfp_device_i (
    .clk(clk), .rst_n(rst_n), .port(port_if), .start_decode(start_decode), .start_encode(start_encode),
    .stop(stop), .header_en(header_en), .monitor_en(monitor_en), .mute(mute), .volume(volume),
    .dl_we(dl_we), .dl_addr(dl_addr), .dl_data(dl_data), .dl_run(dl_run), .dl_rdata(dl_rdata),
    .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready), .out_sample(out_sample),
    .out_valid(out_valid), .mode(mode), .code_loaded(code_loaded), .underrun(underrun), .late(late),
    .overflow(overflow));
  cfp_host cfp_host_i (.clk(clk), .rst_n(rst_n), .port(port_if), .read_en(read_en), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
  cfp_checker #(.FRAME_CYC(FRAME_T)) cfp_checker_i (.clk(clk), .rst_n(rst_n),
    .host_request_line(port_if.host_request_line), .read_strobe_n(port_if.read_strobe_n),
    .byte_avail_n(port_if.byte_avail_n), .frame_request(port_if.frame_request),
    .dev_dout(port_if.dev_dout), .dev_oe_n(port_if.dev_oe_n), .parallel_port(port_if.parallel_port));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Coded byte i of the sign-bit encoder, first sample in the msb
  function automatic logic [7:0] enc_byte(int i);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[7-j] = ~ins[8*i+j][15];
    return b;
  endfunction
  // Played sample k; the second frame is sent muted
  function automatic logic [15:0] dec_exp(int k);
    if (k >= 80) return 16'h0000;
    return frm[k/8][7-k%8] ? volume : 16'(-volume);
  endfunction
  task summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle command level: 0 decode, 1 encode, 2 stop, 3 run
  task cmd(input int c);
    @(posedge clk);
    start_decode <= (c == 0);
    start_encode <= (c == 1);
    stop <= (c == 2);
    dl_run <= (c == 3);
    @(posedge clk);
    {start_decode, start_encode, stop, dl_run} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task dl_write(input logic [9:0] a, input logic [19:0] v);
    @(posedge clk);
    dl_addr <= a;
    dl_data <= v;
    dl_we <= 1'b1;
    @(posedge clk);
    dl_we <= 1'b0;
  endtask
  task dl_check(input logic [9:0] a, input logic [19:0] v);
    @(posedge clk);
    dl_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    `CHK("download word", v, dl_rdata)
  endtask
  // Samples are paced like a real audio source, one every 16 cycles; in_ready is refused while a byte pair or header burst waits for the output buffer
  task feed(input int cnt);
    logic [15:0] s;
    for (int k = 0; k < cnt; k++) begin
      s = (k == 0) ? 16'h8000 : ((k == 1) ? 16'h7FFF : 16'($urandom));
      @(posedge clk);
      in_sample <= s;
      in_valid <= 1'b1;
      ins.push_back(s);
      @(posedge clk);
      in_valid <= 1'b0;
      repeat (14) @(posedge clk);
    end
  endtask
  task send(input logic [7:0] b);
    @(posedge clk);
    tx_byte <= b;
    tx_valid <= 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    tx_valid <= 1'b0;
  endtask
  // ----------------------------------------
  // Clock, collectors, watchdog
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  // Capture what the host reads and what the device plays or echoes
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (out_valid === 1'b1) outq.push_back(out_sample);
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(89454));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Commands and program download
    cmd(1);
    `CHK("encode refused", CFP_IDLE, mode)
    for (int i = 0; i < 4; i++) begin
      tdv[i] = 20'($urandom);
      dl_write(ta[i], tdv[i]);
    end
    `CHK("mode after write", CFP_IDLE, mode)
    `CHK("code loaded", 1'b1, code_loaded)
    for (int i = 0; i < 4; i++) dl_check(ta[i], tdv[i]);
    cmd(3);
    `CHK("run mode", CFP_PROGRAM, mode)
    cmd(0);
    `CHK("decode blocked", CFP_PROGRAM, mode)
    dl_write(ta[2], ~tdv[2]);
    cmd(2);
    dl_check(ta[2], tdv[2]);
    // Encode one frame with header and echo
    header_en <= 1'b1;
    monitor_en <= 1'b1;
    read_en <= 1'b1;
    cmd(1);
    `CHK("encode mode", CFP_ENCODE, mode)
    repeat (20) @(posedge clk);
    feed(80);
    repeat (1500) @(posedge clk);
    `CHK("bytes read", 20, rxq.size())
    for (int i = 0; i < 20; i++) `CHK("coded byte", (i < 10) ? HDR_BYTE : enc_byte((i - 10) ^ 1), rxq[i])
    `CHK("echo count", 80, outq.size())
    for (int i = 0; i < 80; i++) `CHK("echo sample", ins[i], outq[i])
    `CHK("no overflow", 1'b0, overflow)
    // Host late: buffer fills, then overruns
    cmd(2);
    read_en <= 1'b0;
    header_en <= 1'b0;
    monitor_en <= 1'b0;
    rxq.delete();
    ins.delete();
    cmd(1);
    feed(120);
    `CHK("late tolerated", 1'b0, overflow)
    feed(40);
    `CHK("overrun seen", 1'b1, overflow)
    `CHK("input refused", 1'b0, in_ready)
    `CHK("buffer held", 1'b0, port_if.byte_avail_n)
    read_en <= 1'b1;
    repeat (1600) @(posedge clk);
    `CHK("drained", 1'b1, port_if.byte_avail_n)
    `CHK("bytes kept", 18, rxq.size())
    for (int i = 0; i < 18; i++) `CHK("kept byte", enc_byte(i ^ 1), rxq[i])
    cmd(2);
    // Decode two frames, the second muted, then starve the device
    read_en <= 1'b0;
    volume <= 16'($urandom);
    outq.delete();
    for (int i = 0; i < 20; i++) frm[i] = (i < 2) ? {8{i[0]}} : 8'($urandom);
    `CHK("no request idle", 1'b0, port_if.frame_request)
    cmd(0);
    `CHK("decode mode", CFP_DECODE, mode)
    for (int i = 0; i < 10; i++) send(frm[i]);
    for (int t = 0; t < 3000 && outq.size() < 80; t++) @(posedge clk);
    mute <= 1'b1;
    for (int i = 10; i < 20; i++) send(frm[i]);
    for (int t = 0; t < 3000 && outq.size() < 160; t++) @(posedge clk);
    for (int k = 0; k < 160; k++) `CHK("played sample", dec_exp(k), outq[k])
    `CHK("no underrun", 1'b0, underrun)
    `CHK("not late", 1'b0, late)
    repeat (1800) @(posedge clk);
    `CHK("underrun", 1'b1, underrun)
    repeat (2000) @(posedge clk);
    `CHK("late", 1'b1, late)
    cmd(2);
    summarize();
  end
endmodule
`default_nettype wire
